/* verilog/dpl_map.svh */
// register offsets, field positions, reset values and limits of the divider and lock block
`ifndef DPL_MAP_SVH
`define DPL_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define DPL_OFS_CTRL      12'h000
`define DPL_OFS_LOOP1_REF 12'h004
`define DPL_OFS_LOOP1_FB  12'h008
`define DPL_OFS_CHDIV     12'h00c
`define DPL_OFS_LOOP2_REF 12'h010
`define DPL_OFS_LOOP2_N   12'h014
`define DPL_OFS_LOOP2_CAL 12'h018
`define DPL_OFS_WINDOW    12'h01c
`define DPL_OFS_CNT1      12'h020
`define DPL_OFS_CNT2      12'h024
`define DPL_OFS_STATUS    12'h028
`define DPL_OFS_IRQ_STAT  12'h02c
`define DPL_OFS_IRQ_MASK  12'h030

// ---------------------------------------------------------------
// ctrl fields
// ---------------------------------------------------------------
`define DPL_CTRL_MODE_LSB   0
`define DPL_CTRL_VCO_SEL    3
`define DPL_CTRL_OSC_DIV    4
`define DPL_CTRL_DOUBLER    5
`define DPL_CTRL_FB_MUX     6
`define DPL_CTRL_HOLD_SET   7
`define DPL_CTRL_CLKIN_SEL  8

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DPL_RST_CTRL      32'h0000_0000
`define DPL_RST_LOOP1_REF 32'h0011_0001
`define DPL_RST_LOOP1_FB  32'h0101_0001
`define DPL_RST_CHDIV     32'h0001_0001
`define DPL_RST_LOOP2_REF 32'h0002_0001
`define DPL_RST_LOOP2_N   32'h0000_0001
`define DPL_RST_WINDOW    32'h0000_0404
`define DPL_RST_CNT       32'h0001_0001

// ---------------------------------------------------------------
// divide limits
// ---------------------------------------------------------------
`define DPL_P_MIN 3'h2
`define DPL_P_MAX 4'h8
`define DPL_N_MIN 19'h0_0001
`define DPL_N_MAX 19'h4_03e7

`endif

/* verilog/dpl_pkg.sv */
// types shared by the divider and lock block
package dpl_pkg;
  // operating modes of the clock conditioner
  typedef enum logic [2:0] {
    DPL_DUAL_INT      = 3'b000,
    DPL_DUAL_INT_ZD   = 3'b001,
    DPL_DUAL_EXT_ZD   = 3'b010,
    DPL_SINGLE_INT    = 3'b011,
    DPL_SINGLE_INT_ZD = 3'b100,
    DPL_DUAL_EXT      = 3'b101,
    DPL_SINGLE_EXT    = 3'b110
  } dpl_mode_t;
endpackage : dpl_pkg

/* verilog/dpl_top.sv */
// divider paths, digital lock detection and apb registers of the dual loop clock block
//
// Contract
// - loop1 reference: selected input divided by its pre-divider times loop1 reference divider.
// - loop1 feedback internal: vcxo over loop1 fb divider, osc divider when output divided.
// - loop1 feedback zero-delay: vco, optional post divider, mux-chosen output channel divider.
// - loop2 reference: osc input over loop2 reference divider, doubled first when enabled.
// - loop2 feedback internal vco: prescaler times n, post divider first when selected.
// - single-loop zero-delay: output channel divider replaces prescaler before n divider.
// - during calibration internal modes use calibration n with prescaler instead of n.
// - prescaler accepts every divide from two through eight.
// - n divider accepts every divide from one through 263143.
// - calibration n differs only single-loop zero-delay; ignored with external vco.
// - three lock events: loop1, loop2, holdover exit with own counts.
// - lock event only after lock count in-window phase detector cycles.
// - any out-of-window cycle resets accumulated count to zero.
// - loop lock event asserts that loop's lock indication.
// - holdover exit event leaves holdover mode.
`timescale 1ns/1ns
`include "dpl_map.svh"

// ---------------------------------------------------------------
// pulse divider
// ---------------------------------------------------------------
module dpl_div #(
  parameter int W = 19
) (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  // edge stream
  input  wire logic         i_in,
  input  wire logic [W-1:0] i_div,
  output logic              o_out
);
  logic [W-1:0] cnt;
  logic         last;
  assign last = (i_div <= W'(1)) || (cnt >= i_div - W'(1));

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cnt <= '0;
    end else if (i_in) begin
      cnt <= last ? '0 : cnt + W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_out <= 1'b0;
    end else begin
      o_out <= i_in && last;
    end
  end

  a_div_emit : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_in && (i_div > W'(1)) && (cnt == i_div - W'(1)) |=> o_out)
    else $error("divider missed its output edge");
endmodule : dpl_div

// ---------------------------------------------------------------
// digital lock detector
// ---------------------------------------------------------------
module dpl_lock (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // phase detector edges
  input  wire logic        i_enable,
  input  wire logic        i_ref,
  input  wire logic        i_fb,
  input  wire logic [7:0]  i_window,
  input  wire logic [13:0] i_count,
  // result
  output logic             o_locked,
  output logic             o_event
);
  logic [7:0]  since_fb;
  logic [7:0]  wait_cnt;
  logic        pending;
  logic [13:0] cnt;
  logic [13:0] target;
  logic        eval_in;
  logic        eval_out;
  logic        early_ok;

  assign target   = (i_count == 14'h0000) ? 14'h0001 : i_count;
  assign early_ok = i_fb || (since_fb <= i_window);

  always_comb begin
    eval_in  = 1'b0;
    eval_out = 1'b0;
    if (pending && i_fb) begin
      eval_in = 1'b1;
    end else if (pending && (wait_cnt >= i_window || i_ref)) begin
      eval_out = 1'b1;
    end else if (i_ref && early_ok) begin
      eval_in = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      since_fb <= 8'hff;
    end else if (i_fb) begin
      since_fb <= 8'h00;
    end else if (since_fb != 8'hff) begin
      since_fb <= since_fb + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || !i_enable) begin
      pending  <= 1'b0;
      wait_cnt <= 8'h00;
    end else if (i_ref && !early_ok && !(pending && i_fb)) begin
      pending  <= 1'b1;
      wait_cnt <= 8'h00;
    end else if (eval_in || eval_out) begin
      pending  <= 1'b0;
    end else if (pending) begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || !i_enable) begin
      cnt <= 14'h0000;
    end else if (eval_out) begin
      cnt <= 14'h0000;
    end else if (eval_in && cnt < target) begin
      cnt <= cnt + 14'h0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || !i_enable) begin
      o_locked <= 1'b0;
      o_event  <= 1'b0;
    end else begin
      o_event <= eval_in && !o_locked && (cnt + 14'h0001 >= target);
      if (eval_out) begin
        o_locked <= 1'b0;
      end else if (eval_in && cnt + 14'h0001 >= target) begin
        o_locked <= 1'b1;
      end
    end
  end

  a_lock_count_reset : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_enable && eval_out |=> cnt == 14'h0000 && !o_locked)
    else $error("count not cleared after out-of-window cycle");

  a_lock_needs_count : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(o_locked) |-> $past(cnt) + 14'h0001 >= target && $past(eval_in))
    else $error("lock asserted before lock count reached");

  a_lock_event_pulse : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_event |-> o_locked && !$past(o_locked))
    else $error("lock event without fresh lock");
endmodule : dpl_lock

// ---------------------------------------------------------------
// top level
// ---------------------------------------------------------------
module dpl_top (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // clock edge streams, one pulse per edge
  input  wire logic        i_clkin0_edge,
  input  wire logic        i_clkin1_edge,
  input  wire logic        i_osc_rise,
  input  wire logic        i_osc_fall,
  input  wire logic        i_vco_edge,
  input  wire logic        i_vco_cal,
  input  wire logic        i_holdover_enter,
  // phase detector edges
  output logic             o_pd1_ref,
  output logic             o_pd1_fb,
  output logic             o_pd2_ref,
  output logic             o_pd2_fb,
  // status
  output logic             o_loop1_locked,
  output logic             o_loop2_locked,
  output logic             o_holdover,
  output logic             o_irq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl, l1_ref, l1_fb, chdiv, l2_ref, l2_n, l2_cal, window, cnt1, cnt2;
  logic [2:0]  irq_stat, irq_mask;
  logic        wr_en, rd_en, addr_ok;
  logic        int_vco, zero_dly, single_zd, cal_on, use_vdiv;
  dpl_pkg::dpl_mode_t mode;
  assign mode  = dpl_pkg::dpl_mode_t'(ctrl[`DPL_CTRL_MODE_LSB +: 3]);
  assign wr_en = i_psel && i_penable && i_pwrite && !o_pready;
  assign rd_en = i_psel && i_penable && !i_pwrite && !o_pready;

  always_comb begin
    case (i_paddr)
      `DPL_OFS_CTRL, `DPL_OFS_LOOP1_REF, `DPL_OFS_LOOP1_FB, `DPL_OFS_CHDIV,
      `DPL_OFS_LOOP2_REF, `DPL_OFS_LOOP2_N, `DPL_OFS_LOOP2_CAL, `DPL_OFS_WINDOW,
      `DPL_OFS_CNT1, `DPL_OFS_CNT2, `DPL_OFS_STATUS, `DPL_OFS_IRQ_STAT,
      `DPL_OFS_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ctrl   <= `DPL_RST_CTRL;
      l1_ref <= `DPL_RST_LOOP1_REF;
      l1_fb  <= `DPL_RST_LOOP1_FB;
      chdiv  <= `DPL_RST_CHDIV;
      l2_ref <= `DPL_RST_LOOP2_REF;
      l2_n   <= `DPL_RST_LOOP2_N;
      l2_cal <= `DPL_RST_LOOP2_N;
      window <= `DPL_RST_WINDOW;
      cnt1   <= `DPL_RST_CNT;
      cnt2   <= `DPL_RST_CNT;
      irq_mask <= 3'h0;
    end else if (wr_en) begin
      case (i_paddr)
        `DPL_OFS_CTRL:      ctrl   <= {23'h000000, i_pwdata[8:0]};
        `DPL_OFS_LOOP1_REF: l1_ref <= {8'h00, i_pwdata[23:16], 2'h0, i_pwdata[13:0]};
        `DPL_OFS_LOOP1_FB:  l1_fb  <= {5'h00, i_pwdata[26:24], 5'h00, i_pwdata[18:16],
                                       2'h0, i_pwdata[13:0]};
        `DPL_OFS_CHDIV:     chdiv  <= {5'h00, i_pwdata[26:16], 5'h00, i_pwdata[10:0]};
        `DPL_OFS_LOOP2_REF: l2_ref <= {13'h0000, i_pwdata[18:16], 4'h0, i_pwdata[11:0]};
        `DPL_OFS_LOOP2_N:   l2_n   <= {13'h0000, i_pwdata[18:0]};
        `DPL_OFS_LOOP2_CAL: l2_cal <= {13'h0000, i_pwdata[18:0]};
        `DPL_OFS_WINDOW:    window <= {16'h0000, i_pwdata[15:0]};
        `DPL_OFS_CNT1:      cnt1   <= {2'h0, i_pwdata[29:16], 2'h0, i_pwdata[13:0]};
        `DPL_OFS_CNT2:      cnt2   <= {18'h00000, i_pwdata[13:0]};
        `DPL_OFS_IRQ_MASK:  irq_mask <= i_pwdata[2:0];
        default: ;
      endcase
    end
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && !addr_ok;
      if (rd_en) begin
        case (i_paddr)
          `DPL_OFS_CTRL:      o_prdata <= ctrl;
          `DPL_OFS_LOOP1_REF: o_prdata <= l1_ref;
          `DPL_OFS_LOOP1_FB:  o_prdata <= l1_fb;
          `DPL_OFS_CHDIV:     o_prdata <= chdiv;
          `DPL_OFS_LOOP2_REF: o_prdata <= l2_ref;
          `DPL_OFS_LOOP2_N:   o_prdata <= l2_n;
          `DPL_OFS_LOOP2_CAL: o_prdata <= l2_cal;
          `DPL_OFS_WINDOW:    o_prdata <= window;
          `DPL_OFS_CNT1:      o_prdata <= cnt1;
          `DPL_OFS_CNT2:      o_prdata <= cnt2;
          `DPL_OFS_STATUS:    o_prdata <= {28'h0000000, cal_on, o_holdover,
                                           o_loop2_locked, o_loop1_locked};
          `DPL_OFS_IRQ_STAT:  o_prdata <= {29'h00000000, irq_stat};
          `DPL_OFS_IRQ_MASK:  o_prdata <= {29'h00000000, irq_mask};
          default:            o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  assign int_vco   = (mode == dpl_pkg::DPL_DUAL_INT) || (mode == dpl_pkg::DPL_DUAL_INT_ZD)
                  || (mode == dpl_pkg::DPL_SINGLE_INT) || (mode == dpl_pkg::DPL_SINGLE_INT_ZD);
  assign zero_dly  = (mode == dpl_pkg::DPL_DUAL_INT_ZD) || (mode == dpl_pkg::DPL_DUAL_EXT_ZD);
  assign single_zd = (mode == dpl_pkg::DPL_SINGLE_INT_ZD);
  assign cal_on    = i_vco_cal && int_vco;
  assign use_vdiv  = ctrl[`DPL_CTRL_VCO_SEL] && int_vco;

  // ---------------------------------------------------------------
  // loop1 reference path
  // ---------------------------------------------------------------
  logic pre0_out, pre1_out, l1_ref_in, l1_ref_out;

  dpl_div #(.W(4)) u_pre0 (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_in(i_clkin0_edge), .i_div(l1_ref[19:16]), .o_out(pre0_out));
  dpl_div #(.W(4)) u_pre1 (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_in(i_clkin1_edge), .i_div(l1_ref[23:20]), .o_out(pre1_out));
  assign l1_ref_in = ctrl[`DPL_CTRL_CLKIN_SEL] ? pre1_out : pre0_out;
  dpl_div #(.W(14)) u_l1r (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_in(l1_ref_in), .i_div(l1_ref[13:0]), .o_out(l1_ref_out));

  // ---------------------------------------------------------------
  // shared vco post divider and channel divider
  // ---------------------------------------------------------------
  logic vdiv_out, vco_path, ch_out;
  logic [10:0] ch_div;
  dpl_div #(.W(3)) u_vdiv (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_in(i_vco_edge), .i_div(l1_fb[26:24]), .o_out(vdiv_out));
  assign vco_path = use_vdiv ? vdiv_out : i_vco_edge;
  assign ch_div = ctrl[`DPL_CTRL_FB_MUX] ? chdiv[26:16] : chdiv[10:0];
  dpl_div #(.W(11)) u_ch (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_in(vco_path), .i_div(ch_div), .o_out(ch_out));

  // ---------------------------------------------------------------
  // loop1 feedback path
  // ---------------------------------------------------------------
  logic oscd_out, l1_fb_in, l1_fb_out;
  dpl_div #(.W(3)) u_oscd (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_in(i_osc_rise), .i_div(l1_fb[18:16]), .o_out(oscd_out));

  assign l1_fb_in = zero_dly ? ch_out
                  : (ctrl[`DPL_CTRL_OSC_DIV] ? oscd_out : i_osc_rise);
  dpl_div #(.W(14)) u_l1n (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_in(l1_fb_in), .i_div(l1_fb[13:0]), .o_out(l1_fb_out));

  // ---------------------------------------------------------------
  // loop2 reference path
  // ---------------------------------------------------------------
  logic l2_ref_in, l2_ref_out;
  assign l2_ref_in = i_osc_rise || (ctrl[`DPL_CTRL_DOUBLER] && i_osc_fall);
  dpl_div #(.W(12)) u_l2r (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_in(l2_ref_in), .i_div(l2_ref[11:0]), .o_out(l2_ref_out));

  // ---------------------------------------------------------------
  // loop2 feedback path
  // ---------------------------------------------------------------
  logic [2:0]  p_eff;
  logic [18:0] n_raw, n_eff;
  logic        p_out, l2_n_in, l2_fb_out, l2_src;

  assign p_eff = (l2_ref[18:16] < `DPL_P_MIN) ? `DPL_P_MIN : l2_ref[18:16];
  assign l2_src = int_vco ? vco_path : i_vco_edge;
  dpl_div #(.W(4)) u_p (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_in(l2_src), .i_div((l2_ref[18:16] == 3'h0) ? `DPL_P_MAX : {1'b0, p_eff}),
    .o_out(p_out));

  // prescaler or channel divider, then n or calibration n
  // calibration n only with internal vco
  assign n_raw   = cal_on ? l2_cal[18:0] : l2_n[18:0];
  assign l2_n_in = (single_zd && !cal_on) ? ch_out : p_out;
  assign n_eff = (n_raw < `DPL_N_MIN) ? `DPL_N_MIN
               : ((n_raw > `DPL_N_MAX) ? `DPL_N_MAX : n_raw);
  dpl_div #(.W(19)) u_l2n (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_in(l2_n_in), .i_div(n_eff), .o_out(l2_fb_out));

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_pd1_ref <= 1'b0;
      o_pd1_fb  <= 1'b0;
      o_pd2_ref <= 1'b0;
      o_pd2_fb  <= 1'b0;
    end else begin
      o_pd1_ref <= l1_ref_out;
      o_pd1_fb  <= l1_fb_out;
      o_pd2_ref <= l2_ref_out;
      o_pd2_fb  <= l2_fb_out;
    end
  end

  // ---------------------------------------------------------------
  // lock detection
  // ---------------------------------------------------------------
  logic lk1, lk2, ev1, ev2, evh;

  // three detectors, holdover on loop1 window
  dpl_lock u_lock1 (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_enable(1'b1),
    .i_ref(l1_ref_out), .i_fb(l1_fb_out), .i_window(window[7:0]), .i_count(cnt1[13:0]),
    .o_locked(lk1), .o_event(ev1));
  dpl_lock u_lock2 (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_enable(1'b1),
    .i_ref(l2_ref_out), .i_fb(l2_fb_out), .i_window(window[15:8]), .i_count(cnt2[13:0]),
    .o_locked(lk2), .o_event(ev2));
  dpl_lock u_lockh (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_enable(o_holdover),
    .i_ref(l1_ref_out), .i_fb(l1_fb_out), .i_window(window[7:0]), .i_count(cnt1[29:16]),
    .o_locked(), .o_event(evh));

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_loop1_locked <= 1'b0;
      o_loop2_locked <= 1'b0;
    end else begin
      o_loop1_locked <= lk1;
      o_loop2_locked <= lk2;
    end
  end

  // holdover exit; entry wins on a tie
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_holdover <= 1'b0;
    end else if (i_holdover_enter || (wr_en && i_paddr == `DPL_OFS_CTRL
                                      && i_pwdata[`DPL_CTRL_HOLD_SET])) begin
      o_holdover <= 1'b1;
    end else if (evh) begin
      o_holdover <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_en && i_paddr == `DPL_OFS_IRQ_STAT) ? i_pwdata[2:0] : 3'h0))
                | {evh, ev2, ev1};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_lock1_event;
    ev1 ##1 1'b1;
  endsequence

  a_loop1_lock_out : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(lk1) |=> o_loop1_locked)
    else $error("loop1 lock indication missing");

  a_loop2_lock_out : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(lk2) |=> o_loop2_locked)
    else $error("loop2 lock indication missing");

  a_holdover_exit : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    evh && !i_holdover_enter && !wr_en |=> !o_holdover)
    else $error("holdover not left after exit event");

  a_ncal_ignored : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !int_vco |-> n_raw == l2_n[18:0])
    else $error("calibration n used with external vco");

  a_doubler_off : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !ctrl[`DPL_CTRL_DOUBLER] |-> l2_ref_in == i_osc_rise)
    else $error("doubler active while disabled");

  a_prescaler_range : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    p_eff >= `DPL_P_MIN)
    else $error("prescaler below two");

  a_n_range : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    n_eff >= `DPL_N_MIN && n_eff <= `DPL_N_MAX)
    else $error("n divider out of range");

  a_irq_sticky : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    s_lock1_event |-> irq_stat[0] ##0 (irq_mask[0] ##1 o_irq) or !irq_mask[0])
    else $error("loop1 lock event not flagged");
endmodule : dpl_top

/* tb/dpl_clk_src.sv */
// partner model: reference input and oscillator edge sources
`timescale 1ns/1ns
module dpl_clk_src (
  // clock and period
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_per,
  // edge pulses
  output logic            o_ref_edge,
  output logic            o_osc_rise,
  output logic            o_osc_fall
);
  logic [7:0] cnt = 8'h00;

  always_ff @(posedge i_clk_sys) begin
    cnt <= (cnt + 8'h01 >= i_per) ? 8'h00 : cnt + 8'h01;
  end

  assign o_ref_edge = (cnt == 8'h00);
  assign o_osc_rise = (cnt == 8'h00);
  // fall mid-period so the two osc edges are evenly spaced
  assign o_osc_fall = (cnt == {1'b0, i_per[7:1]});
endmodule : dpl_clk_src

/* tb/dual_pll_divider_lock_detect_tb.sv */
// self-checking bench for the divider and lock block
`timescale 1ns/1ns
`include "dpl_map.svh"
module dual_pll_divider_lock_detect_tb;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, e;
  logic [11:0] ad = 12'h000;
  logic [31:0] wd = 32'h0, q, prdata, g;
  logic        pready, pslverr, refe, oscr, oscf, irq, lk1;
  logic [1:0]  lv;
  logic [3:0]  pv;
  logic [7:0]  per = 8'h04;
  int          fail_count = 0, compares = 0;

  initial forever #20 clk = ~clk;

  dpl_clk_src i_src (.i_clk_sys(clk), .i_per(per), .o_ref_edge(refe),
    .o_osc_rise(oscr), .o_osc_fall(oscf));

  dpl_top i_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(ad), .i_pwdata(wd), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_clkin0_edge(refe), .i_clkin1_edge(1'b0), .i_osc_rise(oscr),
    .i_osc_fall(oscf), .i_vco_edge(1'b1), .i_vco_cal(1'b0), .i_holdover_enter(1'b0),
    .o_pd1_ref(pv[0]), .o_pd1_fb(pv[3]), .o_pd2_ref(pv[1]), .o_pd2_fb(pv[2]),
    .o_loop1_locked(lk1), .o_loop2_locked(lv[0]), .o_holdover(lv[1]), .o_irq(irq));

  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    compares++;
    if (y !== x) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    ad   <= a;
    wd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    repeat (30) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      fail_count++;
      test_done();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  // cycles between two pulses of a phase detector stream, after two settling pulses
  task automatic gap(input int i);
    repeat (3) begin
      g = 32'h0;
      repeat (200) begin
        @(negedge clk);
        g++;
        if (pv[i] === 1'b1) break;
      end
      if (pv[i] !== 1'b1) begin
        fail_count++;
        test_done();
      end
    end
  endtask : gap

  task automatic wlev(input int k, input logic v);
    repeat (300) begin
      @(negedge clk);
      if (lv[k] === v) break;
    end
    if (lv[k] !== v) begin
      fail_count++;
      test_done();
    end
  endtask : wlev

  task automatic s_regs();
    apb(1'b0, `DPL_OFS_LOOP1_REF, 32'h0);
    chk("loop1 ref reset", `DPL_RST_LOOP1_REF, q);
    apb(1'b0, `DPL_OFS_WINDOW, 32'h0);
    chk("window reset", `DPL_RST_WINDOW, q);
    apb(1'b1, 12'h040, 32'hffff_ffff);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped data", 32'h0, q);
    chk("loop1 locked", 32'h1, {31'h0, lk1});
    chk("holdover idle", 32'h0, {31'h0, lv[1]});
  endtask : s_regs

  task automatic s_ref();
    apb(1'b1, `DPL_OFS_LOOP1_REF, 32'h0002_0003);
    gap(0);
    chk("pd1 ref gap", 32'd24, g);
    apb(1'b1, `DPL_OFS_LOOP1_FB, 32'h0002_0003);
    gap(3);
    chk("pd1 fb gap", 32'd12, g);
    apb(1'b1, `DPL_OFS_CTRL, 32'h10);
    gap(3);
    chk("pd1 fb osc div", 32'd24, g);
    apb(1'b1, `DPL_OFS_CTRL, 32'h0);
    apb(1'b1, `DPL_OFS_LOOP2_REF, 32'h0002_0003);
    gap(1);
    chk("pd2 ref gap", 32'd12, g);
    apb(1'b1, `DPL_OFS_CTRL, 32'h20);
    gap(1);
    chk("pd2 ref doubled", 32'd6, g);
  endtask : s_ref

  task automatic s_fb();
    apb(1'b1, `DPL_OFS_LOOP2_N, 32'h1);
    for (int p = 2; p <= 8; p++) begin
      apb(1'b1, `DPL_OFS_LOOP2_REF, {13'h0, 3'(p), 16'h0003});
      gap(2);
      chk("pd2 fb gap", 32'(p), g);
    end
    apb(1'b1, `DPL_OFS_CHDIV, 32'h5);
    apb(1'b1, `DPL_OFS_CTRL, 32'h24);
    gap(2);
    chk("pd2 fb channel", 32'd5, g);
    apb(1'b1, `DPL_OFS_LOOP1_FB, 32'h0300_0001);
    apb(1'b1, `DPL_OFS_CTRL, 32'h28);
    gap(2);
    chk("pd2 fb vco_post_divider", 32'd24, g);
    apb(1'b1, `DPL_OFS_CTRL, 32'h20);
  endtask : s_fb

  task automatic s_lock();
    // doubled osc over two equals the osc rate; vco over two times two matches it
    apb(1'b1, `DPL_OFS_LOOP2_REF, 32'h0002_0002);
    apb(1'b1, `DPL_OFS_CNT2, 32'h5);
    // mismatched n first, so the later lock is a fresh event
    apb(1'b1, `DPL_OFS_LOOP2_N, 32'h7);
    wlev(0, 1'b0);
    apb(1'b1, `DPL_OFS_IRQ_STAT, 32'h7);
    apb(1'b1, `DPL_OFS_IRQ_MASK, 32'h2);
    apb(1'b1, `DPL_OFS_LOOP2_N, 32'h2);
    wlev(0, 1'b1);
    // irq follows the lock output by one cycle
    @(negedge clk);
    chk("loop2 locked", 32'h1, {31'h0, lv[0]});
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, `DPL_OFS_IRQ_STAT, 32'h0);
    chk("irq stat", 32'h2, q & 32'h2);
    apb(1'b1, `DPL_OFS_IRQ_STAT, 32'h2);
    apb(1'b1, `DPL_OFS_LOOP2_N, 32'h7);
    wlev(0, 1'b0);
    chk("lock lost", 32'h0, {31'h0, lv[0]});
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : s_lock

  task automatic s_hold();
    apb(1'b1, `DPL_OFS_LOOP1_FB, 32'h1);
    apb(1'b1, `DPL_OFS_CTRL, 32'h80);
    chk("holdover entered", 32'h1, {31'h0, lv[1]});
    wlev(1, 1'b0);
    chk("holdover left", 32'h0, {31'h0, lv[1]});
  endtask : s_hold

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_ref();
    s_fb();
    s_lock();
    s_hold();
    test_done();
  end
endmodule : dual_pll_divider_lock_detect_tb
